// File: common/ibe_pkg.sv
`default_nettype none
package ibe_pkg;
	// Mode selection codes.
	typedef enum logic [1:0] {
		IBE_MODE_OFF = 2'b00,
		IBE_MODE_PBYTE = 2'b01,
		IBE_MODE_HECPF = 2'b10
	} ibe_mode_t;
	// Width of the handshake timing register.
	localparam int IBE_TIME_W = 8;
	// Reset values.
	localparam logic [8:0] IBE_WORD_RST = 9'h000;
	localparam logic [IBE_TIME_W-1:0] IBE_TIME_RST = 8'h00;
	// Bit positions within the synchronised handshake input group.
	localparam int IBE_IN_ACTIVE = 0;
	localparam int IBE_IN_BUSY = 1;
	localparam int IBE_IN_HCLK = 2;
	localparam int IBE_IN_INIT = 3;
	localparam int IBE_IN_PACK = 4;
	localparam int IBE_IN_PREQ = 5;
	localparam int IBE_IN_W = 6;
	// Resting level of each handshake input: active, clock, init, request high.
	localparam logic [IBE_IN_W-1:0] IBE_IN_IDLE = 6'h2d;
	// Write strobe carrier from software or DMA.
	typedef struct packed {
		logic wr;
		logic alt;
		logic [7:0] data;
	} ibe_wr_t;
endpackage
`default_nettype wire

// File: logic/ibe_engine.sv
`default_nettype none
module ibe_engine (
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire ibe_pkg::ibe_mode_t i_mode,
	input wire ibe_pkg::ibe_wr_t i_wr,
	input wire logic [ibe_pkg::IBE_TIME_W-1:0] i_handshake_timing_reg,
	input wire logic [ibe_pkg::IBE_IN_W-1:0] i_pins,
	input wire logic i_illegal_clear,
	output logic [7:0] o_parallel_data_pins,
	output logic o_data_oe_b,
	output logic o_ptr_clk,
	output logic o_host_clk,
	output logic o_host_ack,
	output logic o_transfer_request_flag,
	output logic o_idle,
	output logic o_illegal_operation_flag,
	output logic o_status_event
);
	import ibe_pkg::*;

	// Elaboration checks: the logic below indexes the pin group by fixed
	// positions and loads the timing register straight into its counters,
	// so a package edit that breaks either assumption is refused here.
	if (IBE_IN_W != 6) begin : g_bad_pin_width
		$error("pin group must hold exactly six handshake inputs");
	end
	if (IBE_TIME_W < 2) begin : g_bad_time_width
		$error("timing register must be at least two bits wide");
	end
	if (IBE_IN_PREQ >= IBE_IN_W) begin : g_bad_pin_map
		$error("handshake pin map exceeds the pin group");
	end

	// Engine states.
	// The byte engine uses WAIT, SETUP, BUSYHI, HCLKR and BUSYLO.
	// The forward engine uses WAIT, SETUP, ACKHI and ACKLO.
	typedef enum logic [2:0] {
		IBE_S_WAIT = 3'b000,
		IBE_S_SETUP = 3'b001,
		IBE_S_BUSYHI = 3'b010,
		IBE_S_HCLKR = 3'b011,
		IBE_S_BUSYLO = 3'b100,
		IBE_S_ACKHI = 3'b101,
		IBE_S_ACKLO = 3'b110
	} ibe_state_t;

	// Two-stage synchroniser; only the second stage is read by logic.
	// A third stage keeps the previous settled value for edge detection.
	// Reset loads the resting level of every pin, so the release of reset
	// does not look like an edge on a line that simply rests high.
	logic [IBE_IN_W-1:0] sync1_q, sync2_q, prev_q;
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sync1_q <= IBE_IN_IDLE;
			sync2_q <= IBE_IN_IDLE;
			prev_q <= IBE_IN_IDLE;
		end else if (i_ce) begin
			sync1_q <= i_pins;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end
	// Edge flags, one cycle wide, taken from the settled stages.
	// An edge is seen two clocks after the pin moves; the peer must hold
	// each level at least that long.
	logic [IBE_IN_W-1:0] rise, fall;
	assign rise = sync2_q & ~prev_q;
	assign fall = ~sync2_q & prev_q;

	// Current state and the mode seen on the previous clock.
	ibe_state_t st_q, st_d;
	ibe_mode_t mode_q;
	logic [8:0] hold_q, hold_d; // Holding register with ninth bit.
	logic [8:0] stage_q, stage_d; // Input/output register with ninth bit.
	logic full_q, full_d; // Stage has a word not yet strobed out.
	// Handshake flags and strobe registers; every output except the data pins and host ack comes from here.
	logic req_q, req_d, idle_q, idle_d, ill_q, ill_d, legal_q, legal_d;
	logic pclk_q, pclk_d, hclk_q, hclk_d, oe_b_q, oe_b_d, ev_q, ev_d;
	// Counters for the byte setup delay and the forward starvation limit.
	logic [IBE_TIME_W-1:0] cnt_q, cnt_d;
	logic [IBE_TIME_W-1:0] starve_q, starve_d;

	// Next-state logic for both handshake engines.
	// Only one engine runs at a time, picked by the registered mode. A mode
	// change takes one cycle of its own, in which both strobes return high,
	// the stage is forgotten and, unless the new mode is off, the request flags are raised afresh.
	// Software writes always land in the holding register, in WAIT together with the stage, so a
	// word written while the stage is busy waits there instead of
	// overwriting the word that is being strobed out.
	always_comb begin
		st_d = st_q;
		hold_d = hold_q;
		stage_d = stage_q;
		full_d = full_q;
		req_d = req_q;
		idle_d = idle_q;
		// A clear loses to a same-cycle set, so no abort is ever missed.
		ill_d = ill_q & ~i_illegal_clear;
		legal_d = legal_q;
		pclk_d = pclk_q;
		hclk_d = hclk_q;
		cnt_d = cnt_q;
		starve_d = starve_q;
		oe_b_d = 1'b1;
		ev_d = 1'b0;
		// Any software write loads the holding register and clears request, unless mode entry or the WAIT, BUSYLO or ACKLO branch below sets it again.
		if (i_wr.wr) begin
			hold_d = {~i_wr.alt, i_wr.data};
			req_d = 1'b0;
		end
		if (i_mode != mode_q) begin
			// Mode entry: both engines start by asking for a byte.
			st_d = IBE_S_WAIT;
			full_d = 1'b0;
			pclk_d = 1'b1;
			hclk_d = 1'b1;
			legal_d = 1'b0;
			starve_d = '0;
			// Entering off leaves the flags as they were for software to read.
			if (i_mode != IBE_MODE_OFF) begin
				req_d = 1'b1;
				idle_d = 1'b1;
			end
		end else if (mode_q == IBE_MODE_PBYTE) begin
			oe_b_d = ~sync2_q[IBE_IN_ACTIVE];
			ev_d = rise[IBE_IN_ACTIVE] | fall[IBE_IN_ACTIVE]
				| rise[IBE_IN_INIT] | fall[IBE_IN_INIT];
			// Active falling is legal only between host clock rise and busy fall.
			if (fall[IBE_IN_ACTIVE] && !legal_q) begin
				ill_d = 1'b1;
			end
			case (st_q)
				IBE_S_WAIT: begin
					// First byte flows straight through, request stays high.
					if (i_wr.wr) begin
						stage_d = {~i_wr.alt, i_wr.data};
						full_d = 1'b1;
						req_d = 1'b1;
						idle_d = 1'b0;
						cnt_d = i_handshake_timing_reg;
						st_d = IBE_S_SETUP;
					end
				end
				IBE_S_SETUP: begin
					// Data setup delay before the clock falls.
					if (cnt_q == '0) begin
						pclk_d = 1'b0;
						st_d = IBE_S_BUSYHI;
					end else begin
						cnt_d = cnt_q - 1'b1;
					end
				end
				IBE_S_BUSYHI: begin
					if (sync2_q[IBE_IN_BUSY]) begin
						// Host has taken the byte; wait for software if nothing is held.
						if (req_d) begin
							idle_d = 1'b1;
						end else begin
							// A held byte exists, so more data is signalled by the clock.
							idle_d = 1'b0;
							pclk_d = 1'b1;
							st_d = IBE_S_HCLKR;
						end
					end
				end
				IBE_S_HCLKR: begin
					// From this rise until busy falls, an active fall is a legal end.
					if (rise[IBE_IN_HCLK]) begin
						legal_d = 1'b1;
						st_d = IBE_S_BUSYLO;
					end
				end
				IBE_S_BUSYLO: begin
					if (!sync2_q[IBE_IN_BUSY]) begin
						// Host has finished the cycle; present the held byte.
						stage_d = hold_q;
						req_d = 1'b1;
						legal_d = 1'b0;
						cnt_d = i_handshake_timing_reg;
						st_d = IBE_S_SETUP;
					end
				end
				default: st_d = IBE_S_WAIT;
			endcase
		end else if (mode_q == IBE_MODE_HECPF) begin
			oe_b_d = 1'b0;
			ev_d = rise[IBE_IN_PREQ] | fall[IBE_IN_PREQ];
			case (st_q)
				IBE_S_WAIT: begin
					if (i_wr.wr && !full_q) begin
						// Empty stage: pass the word through at once.
						stage_d = {~i_wr.alt, i_wr.data};
						full_d = 1'b1;
						req_d = 1'b1;
						idle_d = 1'b0;
						starve_d = '0;
						st_d = IBE_S_SETUP;
					end else if (!idle_q) begin
						// Starvation timer for the idle indication.
						// The limit shares the register with the byte setup delay; the
						// two engines never run at once, so one register serves both.
						// Idle is left alone once set; only a write clears it.
						if (starve_q >= i_handshake_timing_reg) begin
							idle_d = 1'b1;
						end else begin
							starve_d = starve_q + 1'b1;
						end
					end
				end
				IBE_S_SETUP: begin
					// One clock of data setup has passed; drop the strobe.
					hclk_d = 1'b0;
					st_d = IBE_S_ACKHI;
				end
				IBE_S_ACKHI: begin
					// Peer has latched the word; release the strobe.
					if (sync2_q[IBE_IN_PACK]) begin
						hclk_d = 1'b1;
						st_d = IBE_S_ACKLO;
					end
				end
				IBE_S_ACKLO: begin
					if (!sync2_q[IBE_IN_PACK]) begin
						// The combinational request sees a write in this very cycle, but the stage
						// loads the older hold_q, so a byte written as the ack drops stays in holding.
						if (!req_d) begin
							stage_d = hold_q;
							req_d = 1'b1;
							st_d = IBE_S_SETUP;
						end else begin
							// Nothing held: wait again and restart the starvation count.
							full_d = 1'b0;
							starve_d = '0;
							st_d = IBE_S_WAIT;
						end
					end
				end
				default: st_d = IBE_S_WAIT;
			endcase
		end
	end

	// State registers; the mode register tracks entry edges.
	// Everything holds its value while the clock enable is low, so a frozen
	// engine resumes exactly where it stopped.
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_q <= IBE_S_WAIT;
			mode_q <= IBE_MODE_OFF;
			hold_q <= IBE_WORD_RST;
			stage_q <= IBE_WORD_RST;
			full_q <= 1'b0;
			req_q <= 1'b0;
			idle_q <= 1'b0;
			ill_q <= 1'b0;
			legal_q <= 1'b0;
			pclk_q <= 1'b1;
			hclk_q <= 1'b1;
			cnt_q <= IBE_TIME_RST;
			starve_q <= IBE_TIME_RST;
			oe_b_q <= 1'b1;
			ev_q <= 1'b0;
		end else if (i_ce) begin
			st_q <= st_d;
			mode_q <= i_mode;
			hold_q <= hold_d;
			stage_q <= stage_d;
			full_q <= full_d;
			req_q <= req_d;
			idle_q <= idle_d;
			ill_q <= ill_d;
			legal_q <= legal_d;
			pclk_q <= pclk_d;
			hclk_q <= hclk_d;
			cnt_q <= cnt_d;
			starve_q <= starve_d;
			oe_b_q <= oe_b_d;
			ev_q <= ev_d;
		end
	end

	// Outputs come straight from flip-flops.
	// The data pins are valid whenever the enable output is low.
	// The ninth bit of the stage rides on the acknowledge line, so a command
	// word and its marker always change in the same clock.
	assign o_parallel_data_pins = stage_q[7:0];
	assign o_host_ack = stage_q[8];
	assign o_data_oe_b = oe_b_q;
	assign o_ptr_clk = pclk_q;
	assign o_host_clk = hclk_q;
	assign o_transfer_request_flag = req_q;
	assign o_idle = idle_q;
	assign o_illegal_operation_flag = ill_q;
	assign o_status_event = ev_q;
endmodule
`default_nettype wire

// File: sim/ibe_engine_asserts.sv
`default_nettype none
module ibe_engine_asserts import ibe_pkg::*; (
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire ibe_pkg::ibe_mode_t i_mode,
	input wire ibe_pkg::ibe_wr_t i_wr,
	input wire logic [ibe_pkg::IBE_IN_W-1:0] i_pins,
	input wire logic [7:0] o_parallel_data_pins,
	input wire logic o_data_oe_b,
	input wire logic o_ptr_clk,
	input wire logic o_host_clk,
	input wire logic o_host_ack,
	input wire logic o_transfer_request_flag,
	input wire logic o_idle,
	input wire logic o_illegal_operation_flag,
	input wire logic o_status_event
);
	// One clock domain, so clock and reset are stated once.
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	property p_entry;
		$changed(i_mode) && i_mode != IBE_MODE_OFF |=> o_transfer_request_flag && o_idle;
	endproperty
	a_entry: assert property (p_entry)
		else $error("mode entry flags wrong");
	property p_oe;
		i_mode == IBE_MODE_HECPF && $past(i_mode, 2) == IBE_MODE_HECPF |-> !o_data_oe_b;
	endproperty
	a_oe: assert property (p_oe)
		else $error("forward mode left pins undriven");
	property p_ack;
		i_mode == IBE_MODE_HECPF && i_wr.wr && o_idle |=> o_host_ack == !$past(i_wr.alt);
	endproperty
	a_ack: assert property (p_ack)
		else $error("host ack not the ninth bit");
	// The strobe may only return high once the peer ack has been seen.
	property p_hclk;
		$rose(o_host_clk) |-> $past(i_pins[IBE_IN_PACK], 2);
	endproperty
	a_hclk: assert property (p_hclk)
		else $error("strobe released before ack");
	property p_setup;
		$fell(o_ptr_clk) |-> o_parallel_data_pins == $past(o_parallel_data_pins, 3) && !o_data_oe_b;
	endproperty
	a_setup: assert property (p_setup)
		else $error("byte strobe without setup");
	property p_idle;
		$rose(o_idle) |-> o_transfer_request_flag;
	endproperty
	a_idle: assert property (p_idle)
		else $error("idle set with request clear");
	property p_ill;
		$rose(o_illegal_operation_flag) |-> i_mode == IBE_MODE_PBYTE && !$past(i_pins[IBE_IN_ACTIVE], 2);
	endproperty
	a_ill: assert property (p_ill)
		else $error("illegal flag without active fall");
	property p_evt;
		o_status_event && i_mode == IBE_MODE_HECPF
			|-> $past(i_pins[IBE_IN_PREQ], 2) != $past(i_pins[IBE_IN_PREQ], 5);
	endproperty
	a_evt: assert property (p_evt)
		else $error("event without request edge");
endmodule
`default_nettype wire

// File: sim/ibe_peer.sv
`default_nettype none
module ibe_peer (
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic i_ptr_clk,
	input wire logic i_host_clk,
	input wire logic [3:0] i_lag,
	output logic o_busy,
	output logic o_hclk,
	output logic o_pack
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] cnt; // Cycles left before the next answer.
	// Every answer waits i_lag cycles, so prompt and slow peers both occur.
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt <= 4'h0;
			o_busy <= 1'b0;
			o_hclk <= 1'b1;
			o_pack <= 1'b0;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
		end else begin
			cnt <= i_lag;
			o_pack <= !i_host_clk;
			if (!i_ptr_clk) begin
				o_busy <= 1'b1;
				o_hclk <= 1'b0;
			end else if (o_busy && !o_hclk) begin
				o_hclk <= 1'b1;
			end else begin
				o_busy <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// File: sim/ibe_engine_tb.sv
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
	$display("ERROR %0t: got %h want %h", $time, a, b); end end
module ibe_engine_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import ibe_pkg::*;
	logic i_clock = 0, i_rst_b = 0, act = 1, init = 1, preq = 1, clr = 0;
	ibe_mode_t mode = IBE_MODE_OFF;
	ibe_wr_t wr = '0;
	logic [7:0] tmr = 8'h02, dp;
	logic [3:0] lag = 4'h0;
	logic busy, hclk, pack, ptr, hc, ack, req, idle, ill, evt, oe_b;
	int num_errors = 0, checks = 0, cyc = 0, evts = 0, e0;
	ibe_engine u_ibe_engine (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_ce(1'b1),
		.i_mode(mode), .i_wr(wr), .i_handshake_timing_reg(tmr),
		.i_pins({preq, pack, init, hclk, busy, act}), .i_illegal_clear(clr),
		.o_parallel_data_pins(dp), .o_data_oe_b(oe_b), .o_ptr_clk(ptr), .o_host_clk(hc),
		.o_host_ack(ack), .o_transfer_request_flag(req), .o_idle(idle),
		.o_illegal_operation_flag(ill), .o_status_event(evt));
	ibe_peer u_ibe_peer (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_ptr_clk(ptr),
		.i_host_clk(hc), .i_lag(lag), .o_busy(busy), .o_hclk(hclk), .o_pack(pack));
	initial forever #2.5 i_clock = ~i_clock;
	// Events are one-cycle pulses, so they are counted as they pass.
	// Sampled on the falling edge, away from the edge that launches them.
	always @(negedge i_clock) begin
		cyc++;
		if (evt === 1'b1) evts++;
		if (cyc == 4000) begin
			num_errors++;
			summarize();
		end
	end
	task summarize;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task step(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask
	task put(input logic alt, input logic [7:0] d);
		wr = '{1'b1, alt, d};
		step(1);
		wr.wr = 1'b0;
		step(1);
	endtask
	// Bounded wait on ptr clock (0), host clock (1) or idle (2).
	task wv(input int s, input logic v);
		int n;
		n = 0;
		while ((s == 0 ? ptr : s == 1 ? hc : idle) !== v && n < 300) begin
			step(1);
			n++;
		end
		if (n == 300) begin
			num_errors++;
			$display("ERROR %0t: wait ran out", $time);
		end
	endtask
	task t_ecp;
		mode = IBE_MODE_HECPF;
		step(2);
		`CHK({req, idle, oe_b}, 3'b110)
		put(1'b0, 8'ha5);
		`CHK({ack, idle, dp}, 10'h2a5)
		put(1'b1, 8'h3c);
		wv(1, 1);
		wv(1, 0);
		`CHK({ack, dp}, 9'h03c)
		wv(2, 1);
		`CHK({idle, req}, 2'b11)
		e0 = evts;
		preq = 0;
		step(8);
		`CHK(evts - e0, 1)
		preq = 1;
		step(8);
		`CHK(evts - e0, 2)
		$display("forward test done");
	endtask
	task t_byte;
		mode = IBE_MODE_OFF;
		lag = 4'h5;
		step(2);
		mode = IBE_MODE_PBYTE;
		step(2);
		`CHK({req, idle}, 2'b11)
		put(1'b0, 8'h5a);
		`CHK({oe_b, idle, dp}, 10'h05a)
		wv(0, 0);
		wv(2, 1);
		`CHK({req, ptr}, 2'b10)
		put(1'b0, 8'hc3);
		`CHK({req, idle}, 2'b00)
		wv(0, 1);
		wv(0, 0);
		`CHK({req, dp}, 9'h1c3)
		e0 = evts;
		init = 0;
		step(8);
		`CHK(evts - e0, 1)
		act = 0;
		step(8);
		`CHK(ill, 1'b1)
		`CHK(evts - e0, 2)
		clr = 1;
		step(1);
		clr = 0;
		step(1);
		`CHK(ill, 1'b0)
		mode = IBE_MODE_OFF;
		step(2);
		$display("byte test done");
	endtask
	initial begin
		repeat (10) @(posedge i_clock);
		#1 i_rst_b = 1;
		step(2);
		t_ecp();
		t_byte();
		summarize();
	end
endmodule
bind ibe_engine ibe_engine_asserts u_ibe_engine_asserts (.*);
`default_nettype wire
